/* File: logic/dts_sequencer.sv */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module dts_sequencer
   import dts_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int BLINK_CYCLES = BLINK_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // AXI4-Lite slave
   input wire logic i_awvalid,
   input wire logic [7:0] i_awaddr,
   output logic o_awready,
   input wire logic i_wvalid,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_wready,
   output logic o_bvalid,
   output logic [1:0] o_bresp,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic [7:0] i_araddr,
   output logic o_arready,
   output logic o_rvalid,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   input wire logic i_rready,
   // Operator pins
   input wire logic i_trig,
   input wire logic i_tip_ball,
   // Same-clock inputs from calibration and the discharge network
   input wire logic i_cal_done,
   input wire dts_disc_type i_disc,
   // High-voltage path and indications
   output logic o_hv_en,
   output logic o_fire,
   output logic o_dump,
   output logic o_pol_neg,
   output logic o_hv_led,
   output logic o_kv_blink,
   output logic o_frame,
   output logic o_beep
);
   ////////////////////////////////////////////////////////////////////////
   // Declarations
   dts_state_type state_r;
   dts_ctrl_type ctrl_r;
   logic [7:0] rate_r, wr_addr, rd_addr;
   logic [15:0] preset_r, count_r, meas_r;
   logic rej_r, tmo_r, latched_r;
   logic trig_s1_r, trig_s2_r, trig_f_r, tip_s1_r, tip_s2_r, tip_f_r, tip_seen_r;
   logic [31:0] deb_cnt_r, blink_cnt_r, tmo_cnt_r, acc_r, rd_data;
   logic press, trig_rel, rate_tick, single_mode, valid_arc, stop_run, tmo_hit;
   logic wr_go, rd_go, wr_ok, rej_pulse;
   // Rate limit depends on discharge mode
   function automatic logic rate_ok(input logic [7:0] rate, input logic contact);
      rate_ok = (rate == RATE_SINGLE) ||
                (rate >= RATE_MIN_T && rate <= (contact ? RATE_CON_MAX_T : RATE_AIR_MAX_T));
   endfunction
   // Settings combination check
   function automatic logic ctrl_ok(input dts_ctrl_type c, input logic [7:0] rate, input logic [15:0] cnt);
      ctrl_ok = rate_ok(rate, c.contact) && c.pol != 2'b11 &&
                !(c.pol == POL_ALT && !c.preset_en) &&
                !(c.cont_en && (c.preset_en || cnt != 16'h0000));
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and trigger debounce
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
         tip_s1_r <= 1'b0;
         tip_s2_r <= 1'b0;
      end else begin
         trig_s1_r <= i_trig;
         trig_s2_r <= trig_s1_r;
         tip_s1_r <= i_tip_ball;
         tip_s2_r <= tip_s1_r;
      end
   end
   // Filtered level moves only after a long stable run, so bounce yields no edge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         deb_cnt_r <= 32'h0;
         trig_f_r <= 1'b0;
      end else if (trig_s2_r == trig_f_r) begin
         deb_cnt_r <= 32'h0;
      end else if (deb_cnt_r >= 32'(DEBOUNCE_CYCLES - 1)) begin
         deb_cnt_r <= 32'h0;
         trig_f_r <= trig_s2_r;
      end else begin
         deb_cnt_r <= deb_cnt_r + 32'h1;
      end
   end
   assign press = trig_s2_r && !trig_f_r && deb_cnt_r >= 32'(DEBOUNCE_CYCLES - 1);
   assign trig_rel = !trig_s2_r && trig_f_r && deb_cnt_r >= 32'(DEBOUNCE_CYCLES - 1);
   ////////////////////////////////////////////////////////////////////////
   // Sequence control
   assign single_mode = rate_r == RATE_SINGLE;
   assign valid_arc = i_disc.evt && ((ctrl_r.thr_off && ctrl_r.contact) ||
      ({8'h0, i_disc.charge_v - i_disc.resid_v} * PCT_FULL >= {8'h0, i_disc.charge_v} * ARC_PCT));
   assign tmo_hit = !ctrl_r.contact && tmo_cnt_r >= 32'(TIMEOUT_CYCLES - 1);
   // Stop on second press when latched, on release when held, or on count reaching zero
   assign stop_run = (latched_r && press) || (!latched_r && trig_rel) ||
      (ctrl_r.preset_en && valid_arc && count_r == 16'h0001);
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_r <= S_CAL;
         latched_r <= 1'b0;
      end else begin
         case (state_r)
            S_CAL: begin
               if (i_cal_done) begin
                  state_r <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (press && single_mode) begin
                  state_r <= S_ARMED;
               end else if (press && !(ctrl_r.preset_en && count_r == 16'h0000)) begin
                  state_r <= S_RUN;
                  latched_r <= ctrl_r.preset_en || ctrl_r.cont_en;
               end
            end
            S_ARMED: begin
               if (i_disc.evt) begin
                  state_r <= S_WREL;
               end else if (trig_rel || tmo_hit) begin
                  state_r <= S_IDLE;
               end
            end
            S_RUN: begin
               if (stop_run || tmo_hit) begin
                  state_r <= (latched_r && trig_f_r) ? S_WREL : S_IDLE;
                  latched_r <= 1'b0;
               end
            end
            S_WREL: begin
               if (!trig_f_r) begin
                  state_r <= S_IDLE;
               end
            end
            default: state_r <= S_CAL;
         endcase
      end
   end
   // Rate phase accumulator, cleared at each sequence start
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         acc_r <= 32'h0;
      end else if (state_r != S_RUN) begin
         acc_r <= 32'h0;
      end else if (rate_tick) begin
         acc_r <= acc_r + 32'(rate_r) - 32'(ACC_FULL);
      end else begin
         acc_r <= acc_r + 32'(rate_r);
      end
   end
   assign rate_tick = state_r == S_RUN && acc_r + 32'(rate_r) >= 32'(ACC_FULL);
   // Air timeout counter, restarted by any discharge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         tmo_cnt_r <= 32'h0;
      end else if ((state_r != S_ARMED && state_r != S_RUN) || i_disc.evt || tmo_hit) begin
         tmo_cnt_r <= 32'h0;
      end else begin
         tmo_cnt_r <= tmo_cnt_r + 32'h1;
      end
   end
   // High-voltage path drive
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hv_en <= 1'b0;
         o_fire <= 1'b0;
         o_dump <= 1'b0;
      end else begin
         o_hv_en <= (state_r == S_ARMED || state_r == S_RUN) && !i_disc.evt && !tmo_hit;
         o_fire <= rate_tick && !stop_run;
         o_dump <= i_disc.evt || tmo_hit || (state_r == S_ARMED && trig_rel);
      end
   end
   // Polarity output, alternating after each valid discharge
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pol_neg <= 1'b0;
      end else if (ctrl_r.pol == POL_ALT) begin
         o_pol_neg <= valid_arc ? !o_pol_neg : o_pol_neg;
      end else begin
         o_pol_neg <= ctrl_r.pol == POL_NEG;
      end
   end
   // HV LED blink; also blinks during self-test
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         blink_cnt_r <= 32'h0;
         o_hv_led <= 1'b0;
      end else if (!o_hv_en && state_r != S_CAL) begin
         blink_cnt_r <= 32'h0;
         o_hv_led <= 1'b0;
      end else if (blink_cnt_r >= 32'(BLINK_CYCLES - 1)) begin
         blink_cnt_r <= 32'h0;
         o_hv_led <= !o_hv_led;
      end else begin
         blink_cnt_r <= blink_cnt_r + 32'h1;
      end
   end
   // Arc indications; kV blink and frame cleared on next press, beep is a one-cycle pulse
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_kv_blink <= 1'b0;
         o_frame <= 1'b0;
         o_beep <= 1'b0;
      end else begin
         if (valid_arc && !ctrl_r.thr_off) begin
            o_kv_blink <= 1'b1;
         end else if (press) begin
            o_kv_blink <= 1'b0;
         end
         if (valid_arc && !ctrl_r.contact && single_mode && !ctrl_r.preset_en) begin
            o_frame <= 1'b1;
         end else if (press) begin
            o_frame <= 1'b0;
         end
         o_beep <= rej_pulse || tmo_hit ||
            (valid_arc && !ctrl_r.contact && single_mode && !ctrl_r.preset_en);
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Register bus: write and read each accepted as one unit
   assign wr_go = i_awvalid && i_wvalid && !o_awready && !o_bvalid;
   assign rd_go = i_arvalid && !o_arready && !o_rvalid;
   assign wr_addr = i_awaddr;
   assign rd_addr = i_araddr;
   assign wr_ok = wr_addr == ADDR_CTRL || wr_addr == ADDR_RATE || wr_addr == ADDR_PRESET || wr_addr == ADDR_CMD;
   // Byte enables ignored: every field is taken as a whole word
   assign rej_pulse = wr_go && ((wr_addr == ADDR_CTRL &&
      !ctrl_ok(dts_ctrl_type'(i_wdata[CTRL_W-1:0]), rate_r, count_r)) ||
      (wr_addr == ADDR_RATE && (i_wdata[31:8] != 24'h0 || !rate_ok(i_wdata[7:0], ctrl_r.contact))));
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         o_awready <= wr_go;
         o_wready <= wr_go;
         if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= (wr_ok && !rej_pulse) ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end
   always_comb begin
      case (rd_addr)
         ADDR_CTRL: rd_data = {26'h0, ctrl_r};
         ADDR_RATE: rd_data = {24'h0, rate_r};
         ADDR_PRESET: rd_data = {16'h0, preset_r};
         ADDR_STATUS: rd_data = {19'h0, state_r, 3'h0, tmo_r, rej_r,
                                 state_r == S_RUN, o_hv_en, state_r != S_CAL};
         ADDR_COUNT: rd_data = {16'h0, count_r};
         ADDR_MEAS: rd_data = {16'h0, meas_r};
         default: rd_data = 32'h0;
      endcase
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0;
         o_rresp <= RESP_OKAY;
      end else begin
         o_arready <= rd_go;
         if (rd_go) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_data;
            o_rresp <= (rd_addr <= ADDR_MEAS && rd_addr[1:0] == 2'b00 && rd_addr != ADDR_CMD) ?
                       RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end
   // Settings; tip change overrides mode and loads the single-pulse default
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_r <= CTRL_RST;
         rate_r <= RATE_RST;
         preset_r <= PRESET_RST;
         tip_f_r <= 1'b0;
         tip_seen_r <= 1'b0;
      end else begin
         tip_f_r <= tip_s2_r;
         tip_seen_r <= 1'b1;
         if (!tip_seen_r || tip_f_r != tip_s2_r) begin
            ctrl_r.contact <= !tip_s2_r;
            rate_r <= RATE_RST;
         end else if (wr_go && !rej_pulse && wr_addr == ADDR_CTRL) begin
            ctrl_r <= dts_ctrl_type'(i_wdata[CTRL_W-1:0]);
         end else if (wr_go && !rej_pulse && wr_addr == ADDR_RATE) begin
            rate_r <= i_wdata[7:0];
         end
         if (wr_go && wr_addr == ADDR_PRESET) begin
            preset_r <= i_wdata[15:0];
         end
      end
   end
   // Count, status flags and measured voltage; hardware set wins over clear
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count_r <= 16'h0000;
         meas_r <= 16'h0000;
         rej_r <= 1'b0;
         tmo_r <= 1'b0;
      end else begin
         if (wr_go && wr_addr == ADDR_CMD && i_wdata[CMD_CNT_RST_BIT]) begin
            count_r <= ctrl_r.preset_en ? preset_r : 16'h0000;
         end else if (wr_go && wr_addr == ADDR_PRESET) begin
            count_r <= i_wdata[15:0];
         end else if (valid_arc && ctrl_r.preset_en && count_r != 16'h0000) begin
            count_r <= count_r - 16'h0001;
         end else if (valid_arc && !ctrl_r.preset_en) begin
            count_r <= count_r + 16'h0001;
         end
         if (i_disc.evt && !ctrl_r.contact) begin
            meas_r <= valid_arc ? i_disc.charge_v : 16'h0000;
         end
         if (rej_pulse) begin
            rej_r <= 1'b1;
         end else if (wr_go && wr_addr == ADDR_CMD && i_wdata[CMD_CLR_REJ_BIT]) begin
            rej_r <= 1'b0;
         end
         if (tmo_hit && (state_r == S_ARMED || state_r == S_RUN)) begin
            tmo_r <= 1'b1;
         end else if (wr_go && wr_addr == ADDR_CMD && i_wdata[CMD_CLR_REJ_BIT]) begin
            tmo_r <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   sequence seq_arc_in_single;
      state_r == S_ARMED ##0 i_disc.evt;
   endsequence
   a_single_one_shot: assert property (seq_arc_in_single |=> state_r == S_WREL ##1 !o_hv_en)
      else $error("single mode did not stop after one discharge");
   a_rep_release_stop: assert property (state_r == S_RUN && !latched_r && trig_rel |=> state_r == S_IDLE)
      else $error("held repetition did not stop on release");
   a_preset_zero_end: assert property (state_r == S_RUN && ctrl_r.preset_en && valid_arc &&
      count_r == 16'h0001 |=> state_r != S_RUN)
      else $error("preset sequence not ended at zero");
   a_count_invalid_hold: assert property (ctrl_r.preset_en && i_disc.evt && !valid_arc && !wr_go
      |=> $stable(count_r))
      else $error("invalid discharge changed the count");
   a_count_up_valid: assert property (!ctrl_r.preset_en && valid_arc && !wr_go
      |=> count_r == $past(count_r) + 16'h0001)
      else $error("valid discharge did not advance count");
   a_rate_in_range: assert property (rate_ok(rate_r, ctrl_r.contact))
      else $error("active repetition rate out of range");
   a_alt_needs_preset: assert property (ctrl_r.pol == POL_ALT |-> ctrl_r.preset_en)
      else $error("alternating polarity without preset counting");
   a_cal_blocks_trig: assert property (state_r == S_CAL |=> state_r inside {S_CAL, S_IDLE})
      else $error("trigger accepted before self-test");
   a_arc_dumps: assert property (i_disc.evt |=> o_dump && !o_hv_en)
      else $error("network not dumped after discharge");
   a_meas_zero: assert property (i_disc.evt && !ctrl_r.contact && !valid_arc |=> meas_r == 16'h0000)
      else $error("invalid air discharge not shown as zero");
   a_reject_keeps: assert property (rej_pulse && wr_addr == ADDR_RATE |=> $stable(rate_r) ##0 rej_r)
      else $error("rejected entry was accepted");
endmodule

/* File: shared/dts_pkg.sv */
package dts_pkg;
   // Clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int TIMEOUT_S = 30;
   localparam int TIMEOUT_CYC = CLK_HZ * TIMEOUT_S;
   localparam int DEBOUNCE_MS = 10;
   localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;
   localparam int BLINK_MS = 250;
   localparam int BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
   // Repetition rate in tenths of a hertz; 0 selects single pulse
   localparam int RATE_SCALE = 10;
   localparam int ACC_FULL = CLK_HZ * RATE_SCALE;
   localparam logic [7:0] RATE_SINGLE = 8'h00;
   localparam logic [7:0] RATE_MIN_T = 8'h05;
   localparam logic [7:0] RATE_AIR_MAX_T = 8'hfa;
   localparam logic [7:0] RATE_CON_MAX_T = 8'hc8;
   // Arc judged valid when this share of the charge voltage is gone
   localparam logic [7:0] ARC_PCT = 8'h14;
   localparam logic [7:0] PCT_FULL = 8'h64;
   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_RATE = 8'h04;
   localparam logic [7:0] ADDR_PRESET = 8'h08;
   localparam logic [7:0] ADDR_CMD = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_COUNT = 8'h14;
   localparam logic [7:0] ADDR_MEAS = 8'h18;
   // Field positions
   localparam int CTRL_W = 6;
   localparam int CMD_CNT_RST_BIT = 0;
   localparam int CMD_CLR_REJ_BIT = 1;
   localparam int ST_READY_BIT = 0;
   localparam int ST_HV_BIT = 1;
   localparam int ST_RUN_BIT = 2;
   localparam int ST_REJ_BIT = 3;
   localparam int ST_TMO_BIT = 4;
   localparam int ST_FSM_LSB = 8;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
   localparam logic [7:0] RATE_RST = 8'h00;
   localparam logic [15:0] PRESET_RST = 16'h0000;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Polarity codes
   localparam logic [1:0] POL_POS = 2'b00;
   localparam logic [1:0] POL_NEG = 2'b01;
   localparam logic [1:0] POL_ALT = 2'b10;

   // Bit 5 thr_off .. bit 0 contact
   typedef struct packed {
      logic thr_off;
      logic cont_en;
      logic [1:0] pol;
      logic preset_en;
      logic contact;
   } dts_ctrl_type;

   // Discharge report from the high-voltage network
   typedef struct packed {
      logic evt;
      logic [15:0] charge_v;
      logic [15:0] resid_v;
   } dts_disc_type;

   typedef enum logic [4:0] {
      S_CAL = 5'b00001,
      S_IDLE = 5'b00010,
      S_ARMED = 5'b00100,
      S_RUN = 5'b01000,
      S_WREL = 5'b10000
   } dts_state_type;
endpackage

/* File: verification/dts_net_model.sv */
`timescale 1ns/1ps
// Far side: the charged network arcs only while HV is applied
module dts_net_model
   import dts_pkg::*;
(
   // Clock and sequencer outputs
   input wire logic i_clk,
   input wire logic i_hv_en,
   input wire logic i_fire,
   // Bench commands an arc and its residual voltage
   input wire logic i_arc,
   input wire logic [15:0] i_resid,
   // Report to the sequencer
   output dts_disc_type o_disc
);
   ////////////////////////////////////////
   // Voltages are only good in the report cycle, so scramble them otherwise
   initial o_disc = '0;
   always @(posedge i_clk) begin
      o_disc.evt <= (i_arc | i_fire) & i_hv_en;
      o_disc.charge_v <= ((i_arc | i_fire) & i_hv_en) ? 16'h03e8 : ~o_disc.charge_v;
      o_disc.resid_v <= ((i_arc | i_fire) & i_hv_en) ? i_resid : ~o_disc.resid_v;
   end
endmodule

/* File: verification/dts_sequencer_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin err_total++; $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module dts_sequencer_test;
   import dts_pkg::*;
   localparam logic [1:0] OK = RESP_OKAY;
   localparam logic [1:0] SE = RESP_SLVERR;
   logic i_clk = 0;
   logic i_nrst = 0;
   logic aw = 0, w = 0, b = 0, ar = 0, r = 0, trig = 0, tip = 1, cal = 0, arc = 0, pol, led_q;
   logic [7:0] aa = 0, ra = 0;
   logic [31:0] wd = 0, rd;
   logic [15:0] res = 0;
   logic awr, wr, bv, arr, rv, hv, fire, dump, pneg, led, kvb, frm, beep;
   logic [1:0] br, rr;
   dts_disc_type disc;
   int err_total = 0, n_tests = 0, dumps = 0, beeps = 0, leds = 0, fires = 0, d0, b0, l0;
   ////////////////////////////////////////
   // Short counts keep timeout and blink within the run
   dts_sequencer #(.TIMEOUT_CYCLES(2000), .DEBOUNCE_CYCLES(4), .BLINK_CYCLES(8)) DUT (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_awvalid(aw), .i_awaddr(aa), .o_awready(awr),
      .i_wvalid(w), .i_wdata(wd), .i_wstrb(4'hf), .o_wready(wr), .o_bvalid(bv), .o_bresp(br),
      .i_bready(b), .i_arvalid(ar), .i_araddr(ra), .o_arready(arr), .o_rvalid(rv), .o_rdata(rd),
      .o_rresp(rr), .i_rready(r), .i_trig(trig), .i_tip_ball(tip), .i_cal_done(cal), .i_disc(disc),
      .o_hv_en(hv), .o_fire(fire), .o_dump(dump), .o_pol_neg(pneg), .o_hv_led(led),
      .o_kv_blink(kvb), .o_frame(frm), .o_beep(beep));
   dts_net_model NET (.i_clk(i_clk), .i_hv_en(hv), .i_fire(fire), .i_arc(arc), .i_resid(res), .o_disc(disc));
   initial forever #10 i_clk = ~i_clk;
   // Tallies of one-cycle pulses and LED toggles
   always @(posedge i_clk) begin
      if (dump === 1'b1) dumps++;
      if (beep === 1'b1) beeps++;
      if (fire === 1'b1) fires++;
      if (led !== led_q) leds++;
      led_q = led;
   end
   ////////////////////////////////////////
   // Bus master: address and data held until awready or arready, response ready held until valid
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic done = 0;
      @(posedge i_clk);
      aa <= a;
      wd <= d;
      aw <= 1;
      w <= 1;
      b <= 1;
      while (!done) begin
         @(posedge i_clk);
         if (awr === 1'b1) begin
            aw <= 0;
            w <= 0;
         end
         if (bv === 1'b1) begin
            b <= 0;
            done = 1;
            `CHK("bresp", e, br)
         end
      end
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic done = 0;
      @(posedge i_clk);
      ra <= a;
      ar <= 1;
      r <= 1;
      while (!done) begin
         @(posedge i_clk);
         if (arr === 1'b1) ar <= 0;
         if (rv === 1'b1) begin
            r <= 0;
            done = 1;
            `CHK("rdata", e, rd)
            `CHK("rresp", er, rr)
         end
      end
   endtask
   // Button level held long enough to pass the filter
   task automatic btn(input logic v);
      @(posedge i_clk);
      trig <= v;
      repeat (12) @(posedge i_clk);
   endtask
   task automatic hv_is(input logic v, input int n);
      repeat (n) if (hv !== v) @(posedge i_clk);
      `CHK("hv_en", v, hv)
   endtask
   task automatic zap(input logic [15:0] v);
      @(posedge i_clk);
      res <= v;
      arc <= 1;
      @(posedge i_clk);
      arc <= 0;
      repeat (4) @(posedge i_clk);
   endtask
   task automatic shot(input logic [15:0] v);
      btn(1);
      hv_is(1, 20);
      zap(v);
      btn(0);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////
   // Watchdog well beyond the expected few thousand cycles
   initial begin
      repeat (40000) @(posedge i_clk);
      err_total++;
      test_done();
   end
   initial begin
      repeat (5) @(posedge i_clk);
      i_nrst <= 1;
      repeat (5) @(posedge i_clk);
      rd_reg(ADDR_CTRL, 0, OK);
      rd_reg(ADDR_STATUS, 32'h100, OK);
      rd_reg(8'h1c, 0, SE);
      btn(1);
      `CHK("hv_en", 1'b0, hv)
      btn(0);
      cal <= 1;
      rd_reg(ADDR_STATUS, 32'h201, OK);
      // Single air shot, valid arc then an arc just short of the threshold
      btn(1);
      hv_is(1, 20);
      zap(16'h0320);
      `CHK("dumps", 1, dumps)
      `CHK("beeps", 1, beeps)
      `CHK("frame", 1'b1, frm)
      `CHK("kv", 1'b1, kvb)
      repeat (20) @(posedge i_clk);
      `CHK("hv_en", 1'b0, hv)
      rd_reg(ADDR_COUNT, 1, OK);
      rd_reg(ADDR_MEAS, 32'h3e8, OK);
      btn(0);
      shot(16'h032a);
      `CHK("kv", 1'b0, kvb)
      `CHK("frame", 1'b0, frm)
      rd_reg(ADDR_COUNT, 1, OK);
      rd_reg(ADDR_MEAS, 0, OK);
      // Entry checks
      wr_reg(ADDR_RATE, 32'hfb, SE);
      wr_reg(ADDR_RATE, 32'h04, SE);
      wr_reg(ADDR_CTRL, 32'h08, SE);
      wr_reg(ADDR_CTRL, 32'h0c, SE);
      wr_reg(ADDR_RATE, 32'hfa, OK);
      wr_reg(ADDR_CTRL, 32'h01, SE);
      // Tally of the last beep lands on the edge the write ended on
      @(negedge i_clk);
      `CHK("beeps", 6, beeps)
      rd_reg(ADDR_STATUS, 32'h209, OK);
      wr_reg(ADDR_CMD, 32'h2, OK);
      // Repetitive, counting up while held
      btn(1);
      rd_reg(ADDR_STATUS, 32'h807, OK);
      zap(16'h0320);
      rd_reg(ADDR_COUNT, 2, OK);
      btn(0);
      hv_is(0, 20);
      // Preset run with alternating polarity
      wr_reg(ADDR_CTRL, 32'h0a, OK);
      wr_reg(ADDR_PRESET, 32'h2, OK);
      rd_reg(ADDR_COUNT, 2, OK);
      btn(1);
      btn(0);
      hv_is(1, 20);
      zap(16'h032a);
      rd_reg(ADDR_COUNT, 2, OK);
      pol = pneg;
      zap(16'h0320);
      `CHK("pol", ~pol, pneg)
      rd_reg(ADDR_COUNT, 1, OK);
      zap(16'h0320);
      hv_is(0, 20);
      wr_reg(ADDR_CMD, 32'h1, OK);
      rd_reg(ADDR_COUNT, 2, OK);
      btn(1);
      btn(0);
      hv_is(1, 20);
      btn(1);
      btn(0);
      hv_is(0, 20);
      // Continuous needs preset off and a zero count
      wr_reg(ADDR_CTRL, 32'h12, SE);
      wr_reg(ADDR_CTRL, 32'h00, OK);
      wr_reg(ADDR_CTRL, 32'h10, SE);
      wr_reg(ADDR_CMD, 32'h1, OK);
      rd_reg(ADDR_COUNT, 0, OK);
      wr_reg(ADDR_CTRL, 32'h10, OK);
      btn(1);
      btn(0);
      hv_is(1, 20);
      btn(1);
      btn(0);
      hv_is(0, 20);
      // Air run with no discharge gives up
      wr_reg(ADDR_CTRL, 32'h00, OK);
      d0 = dumps;
      b0 = beeps;
      l0 = leds;
      btn(1);
      hv_is(1, 20);
      hv_is(0, 2200);
      // Let the pulse tallies of the last edge settle first
      @(negedge i_clk);
      `CHK("dumps", d0 + 1, dumps)
      `CHK("beeps", b0 + 1, beeps)
      btn(0);
      // Pointed tip selects contact and single pulse
      tip <= 0;
      repeat (6) @(posedge i_clk);
      rd_reg(ADDR_CTRL, 1, OK);
      rd_reg(ADDR_RATE, 0, OK);
      shot(16'h032a);
      rd_reg(ADDR_MEAS, 32'h3e8, OK);
      wr_reg(ADDR_CTRL, 32'h21, OK);
      shot(16'h03e8);
      rd_reg(ADDR_COUNT, 1, OK);
      // Only toggles seen since the timeout run count, not the self-test blink
      `CHK("hv_led", 1'b1, leds > l0)
      // Every run here is far shorter than one 25 Hz period, so no rate tick may fire
      `CHK("fires", 0, fires)
      // Second power-up restores defaults
      i_nrst <= 0;
      repeat (3) @(posedge i_clk);
      i_nrst <= 1;
      repeat (5) @(posedge i_clk);
      rd_reg(ADDR_CTRL, 1, OK);
      rd_reg(ADDR_COUNT, 0, OK);
      rd_reg(ADDR_PRESET, 0, OK);
      test_done();
   end
endmodule
